// [vsf_pkg.sv]
// constants and types of the valve setpoint and feedback block
package vsf_pkg;
  // ****************************************
  // time base
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  localparam int SAMPLE_S = 5;
  localparam int QUIET_S = 60;
  localparam int HEARTBEAT_MIN = 15;
  localparam int POS_FAST_MS = 500;
  localparam int DI_FAST_S = 3;
  localparam int SYNC_PCT = 130;
  localparam int SAMPLE_TICKS = SAMPLE_S * TICKS_PER_S;
  localparam int QUIET_SAMPLES = QUIET_S / SAMPLE_S;
  localparam int HEARTBEAT_TICKS = HEARTBEAT_MIN * 60 * TICKS_PER_S;
  localparam int POS_FAST_TICKS = POS_FAST_MS / TICK_MS;
  localparam int DI_FAST_TICKS = DI_FAST_S * TICKS_PER_S;
  // ****************************************
  // percent codes, 0.005 % per step
  // ****************************************
  localparam logic signed [15:0] CODE_ZERO = 16'sh0000;
  localparam logic signed [15:0] CODE_FULL = 16'sh4e20;
  localparam logic signed [15:0] CODE_INVALID = 16'sh7fff;
  localparam logic [31:0] STEP_P = 32'h00004e20;
  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_NET_SP = 8'h04;
  localparam logic [7:0] REG_MAN_SP = 8'h08;
  localparam logic [7:0] REG_RCV_TIMEOUT = 8'h0c;
  localparam logic [7:0] REG_SAFETY_POS = 8'h10;
  localparam logic [7:0] REG_RUN_TIME = 8'h14;
  localparam logic [7:0] REG_POS_FB = 8'h18;
  localparam logic [7:0] REG_DI_STATE = 8'h1c;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [15:0] RCV_TIMEOUT_RST = 16'h0000;
  localparam logic [11:0] RUN_TIME_RST = 12'h03c;
  localparam logic [15:0] POR_SYNC_TICKS = 16'(int'(RUN_TIME_RST) * TICKS_PER_S * SYNC_PCT / 100);
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    FIRMWARE_REV_ONE = 2'h0,
    FIRMWARE_REV_TWO = 2'h1,
    LATER_VARIANT = 2'h2
  } vsf_variant_t;
  typedef enum logic [1:0] {
    DI_DIRECT = 2'h0,
    DI_INVERTED = 2'h1,
    DI_UNDEFINED = 2'h2
  } vsf_dicfg_t;
  typedef struct packed {
    vsf_dicfg_t dicfg;
    vsf_variant_t variant;
  } vsf_ctrl_t;
  typedef enum logic [3:0] {
    M_POR = 4'b0001,
    M_SYNC = 4'b0010,
    M_TRACK = 4'b0100,
    M_HOLD = 4'b1000
  } vsf_mode_t;
  typedef struct packed {
    logic motor_close;
    logic motor_open;
    logic wd_trip;
    logic pos_valid;
    vsf_mode_t mode;
  } vsf_status_t;
  typedef struct packed {
    logic [7:0] value;
    logic [7:0] state;
  } vsf_switch_t;
  localparam logic [7:0] SW_VALUE_ON = 8'hc8;
  localparam logic [7:0] SW_STATE_ON = 8'h01;
  localparam logic [7:0] SW_STATE_UNDEF = 8'hff;
  localparam vsf_switch_t SW_OFF = '{value: 8'h00, state: 8'h00};
  localparam vsf_switch_t SW_ON = '{value: SW_VALUE_ON, state: SW_STATE_ON};
  localparam vsf_switch_t SW_UNDEF = '{value: 8'h00, state: SW_STATE_UNDEF};
endpackage : vsf_pkg

// [vsf_top.sv]
// setpoint arbitration, stem model and feedback publishing of the valve actuator
`timescale 1ns/10ps
module vsf_pub import vsf_pkg::*; #(
  parameter int FAST_TICKS = 5,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input logic sys_clk,
  input logic rst,
  input logic tick,
  input vsf_variant_t variant,
  input logic [15:0] value,
  output logic pub,
  output logic [15:0] pub_val
);
  logic [5:0] samp_cnt_q;
  logic [5:0] fast_cnt_q;
  logic [13:0] hb_cnt_q;
  logic [3:0] quiet_q;
  logic quiet_done_q;
  logic sample;
  logic fast;
  logic heartbeat;
  logic changed;
  logic quiet_end;
  logic fire;

  assign sample = tick && (samp_cnt_q == 6'(SAMPLE_TICKS - 1));
  assign fast = tick && (fast_cnt_q == 6'(FAST_TICKS - 1));
  assign heartbeat = tick && (hb_cnt_q == 14'(HEARTBEAT_TICKS - 1));
  assign changed = (value != pub_val);
  assign quiet_end = !quiet_done_q && (quiet_q == 4'(QUIET_SAMPLES - 1));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      samp_cnt_q <= 6'h00;
      fast_cnt_q <= 6'h00;
      hb_cnt_q <= 14'h0000;
    end else if (tick) begin
      samp_cnt_q <= sample ? 6'h00 : samp_cnt_q + 6'h01;
      fast_cnt_q <= fast ? 6'h00 : fast_cnt_q + 6'h01;
      hb_cnt_q <= heartbeat ? 14'h0000 : hb_cnt_q + 14'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      quiet_q <= 4'h0;
      quiet_done_q <= 1'b0;
    end else if (sample) begin
      if (changed) begin
        quiet_q <= 4'h0;
        quiet_done_q <= 1'b0;
      end else if (quiet_end) begin
        quiet_q <= 4'h0;
        quiet_done_q <= 1'b1;
      end else if (!quiet_done_q) begin
        quiet_q <= quiet_q + 4'h1;
      end
    end
  end

  always_comb begin
    case (variant)
      FIRMWARE_REV_ONE: fire = fast;
      FIRMWARE_REV_TWO: fire = sample && (changed || quiet_end);
      default: fire = (sample && changed) || heartbeat;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pub <= 1'b0;
      pub_val <= RST_VAL;
    end else begin
      pub <= fire;
      if (fire) begin
        pub_val <= value;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_rev_one_rate: assert property (
    variant == FIRMWARE_REV_ONE && fast |=> pub && pub_val == $past(value))
    else $error("fixed-rate publish missing");
  a_rev_two_change: assert property (
    variant == FIRMWARE_REV_TWO && sample && changed |=> pub)
    else $error("changed value not published at sample");
  a_rev_two_quiet: assert property (
    variant == FIRMWARE_REV_TWO && sample && !changed && quiet_end |=> pub ##1 !pub)
    else $error("quiet resend missing");
  a_later_spacing: assert property (
    variant == LATER_VARIANT && !sample && !heartbeat |=> !pub)
    else $error("publish outside sample instant");
  a_later_heartbeat: assert property (
    variant == LATER_VARIANT && heartbeat |=> pub && pub_val == $past(value))
    else $error("heartbeat publish missing");
endmodule : vsf_pub

module vsf_top import vsf_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  input logic sys_clk,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic di_in,
  output logic motor_open,
  output logic motor_close,
  output logic pos_pub,
  output logic [15:0] pos_pub_val,
  output logic di_pub,
  output vsf_switch_t di_pub_val
);
  // ****************************************
  // state
  // ****************************************
  logic [19:0] tick_cnt_q;
  logic tick_q;
  vsf_ctrl_t ctrl_q;
  logic signed [15:0] net_sp_q;
  logic signed [15:0] man_sp_q;
  logic [15:0] rcv_timeout_q;
  logic signed [15:0] safety_q;
  logic [11:0] run_time_q;
  logic man_written_q;
  vsf_mode_t mode_q;
  logic [15:0] sync_cnt_q;
  logic sync_up_q;
  logic [31:0] p_q;
  logic pos_valid_q;
  logic por_done_q;
  logic reeval_q;
  logic signed [15:0] pos_fb_q;
  logic [19:0] wd_cnt_q;
  logic wd_trip_q;
  logic wd_set_q;
  vsf_switch_t di_state_q;
  logic acc;
  logic wr;
  logic net_wr;
  logic sp_wr;
  logic [31:0] rd_mux;
  logic signed [15:0] gov_code;
  logic use_safety;
  logic gov_end;
  logic gov_stop;
  logic [15:0] run_ticks;
  logic [15:0] sync_ticks;
  logic [19:0] rcv_ticks;
  logic [31:0] p_full;
  logic [31:0] tp;
  logic [31:0] end_p;
  logic [31:0] fb_raw;
  logic signed [15:0] fb;

  function automatic logic signed [15:0] clamp_sp(input logic signed [15:0] sp);
    if (sp == CODE_INVALID) begin
      return sp;
    end else if (sp < CODE_ZERO) begin
      return CODE_ZERO;
    end else if (sp > CODE_FULL) begin
      return CODE_FULL;
    end
    return sp;
  endfunction : clamp_sp

  function automatic logic is_end(input logic signed [15:0] c);
    return (c == CODE_ZERO) || (c == CODE_FULL);
  endfunction : is_end

  // ****************************************
  // local timebase
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_q <= 20'h00000;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 20'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 20'(TICK_CYCLES - 1)) ? 20'h00000 : tick_cnt_q + 20'h00001;
    end
  end

  // ****************************************
  // apb slave, one wait-free access cycle
  // ****************************************
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign net_wr = wr && (paddr == REG_NET_SP);
  assign sp_wr = net_wr || (wr && (paddr == REG_MAN_SP));

  always_comb begin
    rd_mux = 32'h00000000;
    case (paddr)
      REG_CTRL: rd_mux = {28'h0000000, ctrl_q};
      REG_NET_SP: rd_mux = {16'h0000, net_sp_q};
      REG_MAN_SP: rd_mux = {16'h0000, man_sp_q};
      REG_RCV_TIMEOUT: rd_mux = {16'h0000, rcv_timeout_q};
      REG_SAFETY_POS: rd_mux = {16'h0000, safety_q};
      REG_RUN_TIME: rd_mux = {20'h00000, run_time_q};
      REG_POS_FB: rd_mux = {16'h0000, pos_fb_q};
      REG_DI_STATE: rd_mux = {16'h0000, di_state_q};
      REG_STATUS: rd_mux = {24'h000000, motor_close, motor_open, wd_trip_q, pos_valid_q, mode_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > REG_STATUS || paddr[1:0] != 2'h0);
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= '{dicfg: DI_DIRECT, variant: FIRMWARE_REV_ONE};
      net_sp_q <= CODE_INVALID;
      man_sp_q <= CODE_INVALID;
      rcv_timeout_q <= RCV_TIMEOUT_RST;
      safety_q <= CODE_INVALID;
      run_time_q <= RUN_TIME_RST;
      man_written_q <= 1'b0;
    end else if (wr) begin
      case (paddr)
        REG_CTRL: ctrl_q <= vsf_ctrl_t'(pwdata[3:0]);
        REG_NET_SP: net_sp_q <= pwdata[15:0];
        REG_MAN_SP: begin
          man_sp_q <= pwdata[15:0];
          man_written_q <= 1'b1;
        end
        REG_RCV_TIMEOUT: rcv_timeout_q <= pwdata[15:0];
        REG_SAFETY_POS: safety_q <= pwdata[15:0];
        REG_RUN_TIME: run_time_q <= (pwdata[11:0] == 12'h000) ? 12'h001 : pwdata[11:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // setpoint arbitration
  // ****************************************
  always_comb begin
    use_safety = 1'b0;
    if (man_sp_q != CODE_INVALID) begin
      gov_code = clamp_sp(man_sp_q);
    end else if (wd_trip_q || net_sp_q == CODE_INVALID) begin
      gov_code = safety_q;
      use_safety = 1'b1;
    end else begin
      gov_code = clamp_sp(net_sp_q);
    end
  end
  assign gov_end = is_end(gov_code);
  assign gov_stop = use_safety && !gov_end;

  // ****************************************
  // receive-timeout supervision
  // ****************************************
  assign rcv_ticks = 20'(rcv_timeout_q) * 20'(TICKS_PER_S);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wd_cnt_q <= 20'h00000;
      wd_trip_q <= 1'b0;
      wd_set_q <= 1'b0;
    end else begin
      wd_set_q <= 1'b0;
      if (net_wr || rcv_timeout_q == 16'h0000) begin
        wd_cnt_q <= 20'h00000;
        wd_trip_q <= 1'b0;
      end else if (tick_q && !wd_trip_q) begin
        if (wd_cnt_q == rcv_ticks - 20'h00001) begin
          wd_trip_q <= 1'b1;
          wd_set_q <= 1'b1;
        end else begin
          wd_cnt_q <= wd_cnt_q + 20'h00001;
        end
      end
    end
  end

  // ****************************************
  // stem model and drive sequencing
  // ****************************************
  assign run_ticks = 16'({4'h0, run_time_q} * 16'(TICKS_PER_S));
  assign sync_ticks = 16'({4'h0, run_time_q} * 16'(TICKS_PER_S * SYNC_PCT / 100));
  assign p_full = {16'h0000, CODE_FULL} * {16'h0000, run_ticks};
  assign tp = {16'h0000, gov_code} * {16'h0000, run_ticks};
  assign end_p = (gov_code == CODE_FULL) ? p_full : 32'h00000000;

  always_comb begin
    fb_raw = p_q / {16'h0000, run_ticks};
    fb = (fb_raw > {16'h0000, CODE_FULL}) ? CODE_FULL : fb_raw[15:0];
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reeval_q <= 1'b0;
      pos_fb_q <= CODE_INVALID;
    end else begin
      reeval_q <= sp_wr || wd_set_q || por_done_q;
      pos_fb_q <= pos_valid_q ? fb : CODE_INVALID;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q <= M_POR;
      sync_cnt_q <= POR_SYNC_TICKS;
      sync_up_q <= 1'b0;
      p_q <= 32'h00000000;
      pos_valid_q <= 1'b0;
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= 1'b0;
      if (mode_q != M_POR && reeval_q) begin
        if (gov_stop) begin
          mode_q <= M_HOLD;
        end else if (gov_end) begin
          mode_q <= M_SYNC;
          sync_cnt_q <= sync_ticks;
          sync_up_q <= (gov_code == CODE_FULL);
          p_q <= end_p;
          pos_valid_q <= 1'b1;
        end else begin
          mode_q <= M_TRACK;
        end
      end else begin
        case (mode_q)
          M_POR: begin
            if (tick_q) begin
              if (sync_cnt_q == 16'h0000) begin
                mode_q <= M_HOLD;
                p_q <= 32'h00000000;
                pos_valid_q <= 1'b1;
                por_done_q <= 1'b1;
              end else begin
                sync_cnt_q <= sync_cnt_q - 16'h0001;
              end
            end
          end
          M_SYNC: begin
            if (tick_q) begin
              if (sync_cnt_q == 16'h0000) begin
                mode_q <= M_HOLD;
              end else begin
                sync_cnt_q <= sync_cnt_q - 16'h0001;
              end
            end
          end
          M_TRACK: begin
            if (tick_q && p_q < tp) begin
              p_q <= (tp - p_q > STEP_P) ? p_q + STEP_P : tp;
            end else if (tick_q && p_q > tp) begin
              p_q <= (p_q - tp > STEP_P) ? p_q - STEP_P : tp;
            end
          end
          M_HOLD: ;
          default: mode_q <= M_HOLD;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      motor_open <= 1'b0;
      motor_close <= 1'b0;
    end else begin
      motor_open <= (mode_q == M_SYNC && sync_up_q) || (mode_q == M_TRACK && p_q < tp);
      motor_close <= (mode_q == M_POR) || (mode_q == M_SYNC && !sync_up_q) || (mode_q == M_TRACK && p_q > tp);
    end
  end

  // ****************************************
  // digital input and publishing
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      di_state_q <= SW_UNDEF;
    end else begin
      case (ctrl_q.dicfg)
        DI_DIRECT: di_state_q <= di_in ? SW_ON : SW_OFF;
        DI_INVERTED: di_state_q <= di_in ? SW_OFF : SW_ON;
        default: di_state_q <= SW_UNDEF;
      endcase
    end
  end

  vsf_pub #(.FAST_TICKS(POS_FAST_TICKS), .RST_VAL(CODE_INVALID)) u_pos_pub (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick_q),
    .variant(ctrl_q.variant),
    .value(pos_fb_q),
    .pub(pos_pub),
    .pub_val(pos_pub_val)
  );

  vsf_pub #(.FAST_TICKS(DI_FAST_TICKS), .RST_VAL(SW_UNDEF)) u_di_pub (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick_q),
    .variant(ctrl_q.variant),
    .value(di_state_q),
    .pub(di_pub),
    .pub_val(di_pub_val)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_sync_start;
    reeval_q && mode_q != M_POR && gov_end;
  endsequence
  sequence s_wd_expire;
    tick_q && rcv_timeout_q != 16'h0000 && !wd_trip_q && wd_cnt_q == rcv_ticks - 20'h00001 && !net_wr;
  endsequence

  a_fb_unknown: assert property (
    !pos_valid_q |=> pos_fb_q == CODE_INVALID)
    else $error("feedback shown before position known");
  a_fb_bounded: assert property (
    pos_valid_q |=> pos_fb_q >= CODE_ZERO && pos_fb_q <= CODE_FULL)
    else $error("feedback outside stroke");
  a_end_at_once: assert property (
    s_sync_start |=> pos_valid_q && p_q == $past(end_p))
    else $error("end position not taken at once");
  a_man_off_reset: assert property (
    !man_written_q |-> man_sp_q == CODE_INVALID)
    else $error("manual setpoint not invalid after reset");
  a_sync_length: assert property (
    s_sync_start |=> mode_q == M_SYNC && sync_cnt_q == $past(sync_ticks))
    else $error("sync time wrong");
  a_sync_abort: assert property (
    mode_q == M_SYNC && reeval_q && !gov_end && !gov_stop |=> mode_q == M_TRACK)
    else $error("sync not aborted by new setpoint");
  a_por_kept: assert property (
    mode_q == M_POR && sync_cnt_q != 16'h0000 |=> mode_q == M_POR)
    else $error("reset sync interrupted");
  a_track_step: assert property (
    mode_q == M_TRACK && tick_q && !reeval_q && p_q < tp |=> p_q > $past(p_q) && p_q <= $past(tp))
    else $error("stem model not moving toward target");
  a_man_priority: assert property (
    man_sp_q != CODE_INVALID && $stable(man_sp_q) |-> $stable(gov_code))
    else $error("network setpoint overrode manual");
  a_clamp_range: assert property (
    !use_safety |-> gov_code == CODE_INVALID || (gov_code >= CODE_ZERO && gov_code <= CODE_FULL))
    else $error("setpoint not clamped");
  a_wd_manual: assert property (
    ((man_sp_q != CODE_INVALID) and s_wd_expire) |=> wd_trip_q)
    else $error("supervision stopped in manual");
  a_wd_expire: assert property (
    s_wd_expire |=> wd_trip_q ##1 reeval_q)
    else $error("timeout did not move to safety");
  a_safety_stop: assert property (
    reeval_q && mode_q != M_POR && gov_stop |=> mode_q == M_HOLD ##1 !motor_open && !motor_close)
    else $error("safety stop not taken");
  a_di_code: assert property (
    di_state_q == SW_OFF || di_state_q == SW_ON || di_state_q == SW_UNDEF)
    else $error("illegal input encoding");
  a_di_invert: assert property (
    ctrl_q.dicfg == DI_INVERTED |=> di_state_q == ($past(di_in) ? SW_OFF : SW_ON))
    else $error("input config not applied");
endmodule : vsf_top

// [vsf_ctl_model.sv]
// remote controller model: apb master that sends setpoints and reads status
`timescale 1ns/10ps
module vsf_ctl_model (
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // request held until pready is seen at a rising edge, data taken there
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : vsf_ctl_model

// [testbench.sv]
// self-checking bench for the valve setpoint and feedback block
`timescale 1ns/10ps
module testbench import vsf_pkg::*; ();
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic di_in = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, motor_open, motor_close, pos_pub, di_pub, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, mid;
  logic [31:0] x = 32'h00000034;
  logic [15:0] pos_pub_val;
  vsf_switch_t di_pub_val;
  int n_errors = 0;
  int samples_checked = 0;
  int n;
  initial forever #50 sys_clk = ~sys_clk;
  vsf_ctl_model vsf_ctl_model_i (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  vsf_top #(.TICK_CYCLES(2)) vsf_top_i (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .di_in(di_in), .motor_open(motor_open), .motor_close(motor_close), .pos_pub(pos_pub),
    .pos_pub_val(pos_pub_val), .di_pub(di_pub), .di_pub_val(di_pub_val));
  // ****************************************
  // helpers
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task rd(input logic [7:0] a, input logic [31:0] exp);
    vsf_ctl_model_i.xfer(1'b0, a, 32'h00000000, r, e);
    check(r, exp);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    vsf_ctl_model_i.xfer(1'b1, a, d, r, e);
  endtask : wr
  function logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : rnd
  task next_di();
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (di_pub !== 1'b1 && n < 200);
    if (di_pub !== 1'b1) n_errors++;
  endtask : next_di
  task next_pos();
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pos_pub !== 1'b1 && n < 200);
    if (pos_pub !== 1'b1) n_errors++;
  endtask : next_pos
  task close_out();
    if (n_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    check(32'(pos_pub_val), 32'h00007fff);
    rd(REG_POS_FB, 32'h00007fff);
    rd(REG_MAN_SP, 32'h00007fff);
    vsf_ctl_model_i.xfer(1'b0, 8'h24, 32'h00000000, r, e);
    check(32'(e), 32'h00000001);
    di_in <= 1'b1;
    n = 0;
    do begin
      vsf_ctl_model_i.xfer(1'b0, REG_STATUS, 32'h00000000, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 2000);
    check(32'(r[0]), 32'h00000000);
    check(32'(r[4]), 32'h00000001);
    rd(REG_POS_FB, 32'h00000000);
    wr(REG_NET_SP, 32'h00004e21 + rnd() % 32'h00001000);
    repeat (6) @(posedge sys_clk);
    rd(REG_POS_FB, 32'(CODE_FULL));
    wr(REG_MAN_SP, 32'h00000000);
    repeat (6) @(posedge sys_clk);
    rd(REG_POS_FB, 32'(CODE_ZERO));
    mid = 32'h00000400 + rnd() % 32'h00004000;
    wr(REG_MAN_SP, mid);
    repeat (6) @(posedge sys_clk);
    check(32'({motor_open, motor_close}), 32'h00000002);
    wr(REG_MAN_SP, 32'(CODE_INVALID));
    repeat (6) @(posedge sys_clk);
    rd(REG_POS_FB, 32'(CODE_FULL));
    wr(REG_SAFETY_POS, 32'h00000000);
    wr(REG_MAN_SP, 32'(CODE_FULL));
    wr(REG_RCV_TIMEOUT, 32'h00000001);
    repeat (60) @(posedge sys_clk);
    vsf_ctl_model_i.xfer(1'b0, REG_STATUS, 32'h00000000, r, e);
    check(32'(r[5]), 32'h00000001);
    rd(REG_POS_FB, 32'(CODE_FULL));
    wr(REG_MAN_SP, 32'(CODE_INVALID));
    repeat (6) @(posedge sys_clk);
    rd(REG_POS_FB, 32'(CODE_ZERO));
    wr(REG_CTRL, 32'h00000000);
    next_di();
    next_di();
    check(32'(n), 32'(DI_FAST_TICKS * 2));
    check(32'(di_pub_val), 32'(SW_ON));
    wr(REG_CTRL, 32'h00000008);
    next_di();
    next_di();
    check(32'(di_pub_val), 32'(SW_UNDEF));
    wr(REG_CTRL, 32'h00000002);
    repeat (2) @(posedge sys_clk);
    next_di();
    check(32'(di_pub_val), 32'(SW_ON));
    wr(REG_CTRL, 32'h00000005);
    repeat (2) @(posedge sys_clk);
    next_di();
    check(32'(di_pub_val), 32'(SW_OFF));
    wr(REG_MAN_SP, 32'(CODE_FULL));
    repeat (4) @(posedge sys_clk);
    next_pos();
    check(32'(pos_pub_val), 32'(CODE_FULL));
    close_out();
  end
  initial begin
    #(100 * 20000);
    n_errors++;
    close_out();
  end
endmodule : testbench
